// ---- core/rate_pkg.sv ----
package rate_pkg;
   // ----------------------------------------------------------------
   // register map (byte addresses, one aligned word each)
   // ----------------------------------------------------------------
   localparam logic [7:0] OWN_ADDR_OFS = 8'h00;
   localparam logic [7:0] RATE_DIV_OFS = 8'h04;
   localparam logic [7:0] CTRL_OFS = 8'h08;
   localparam logic [7:0] OWN_ADDR_RST = 8'h00;
   localparam logic [7:0] RATE_DIV_RST = 8'h00;
   // ----------------------------------------------------------------
   // field layout
   // ----------------------------------------------------------------
   localparam int MUL_MSB = 7;
   localparam int MUL_LSB = 6;
   localparam int IDX_MSB = 5;
   localparam int IDX_W = 6;
   localparam int TAB_IDX_W = 5;
   localparam int ADDR_MSB = 7;
   localparam int ADDR_LSB = 1;
   localparam int CTL_START = 0;
   localparam int CTL_STOP = 1;
   localparam int CTL_DATA = 2;
   localparam int STA_BUSY = 0;
   localparam int STA_SCL = 1;
   localparam int STA_SDA = 2;
   localparam int STA_MATCH = 3;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CNT_W = 10;
   localparam int VAL_W = 8;
   localparam logic [CNT_W-1:0] MIN_DIV = 10'h014;
   localparam logic [1:0] MUL_X1 = 2'b00;
   localparam logic [1:0] MUL_X2 = 2'b01;
   localparam logic [1:0] MUL_X4 = 2'b10;
   localparam logic [1:0] AXI_OKAY = 2'b00;
   localparam logic [1:0] AXI_SLVERR = 2'b10;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_START = 3'b001,
      ST_LOW = 3'b010,
      ST_HIGH = 3'b011,
      ST_STOP = 3'b100
   } line_state_e;
endpackage : rate_pkg

// ---- core/rate_if.sv ----
`timescale 1ns/10ps
interface rate_if;
   import rate_pkg::*;
   logic [IDX_W-1:0] rate_index;
   logic [VAL_W-1:0] scl_div;
   logic [VAL_W-1:0] sda_hold;
   logic [VAL_W-1:0] start_hold;
   logic [VAL_W-1:0] stop_hold;
   modport table_side (input rate_index, output scl_div, output sda_hold,
                       output start_hold, output stop_hold);
   modport user_side (output rate_index, input scl_div, input sda_hold,
                      input start_hold, input stop_hold);
endinterface : rate_if

// ---- core/rate_lookup.sv ----
`timescale 1ns/10ps
module rate_lookup (
   rate_if.table_side rif // index in, divider and holds out
);
   import rate_pkg::*;
   logic [4*VAL_W-1:0] row;
   logic [TAB_IDX_W-1:0] idx;

   // ----------------------------------------------------------------
   // divider, data hold, start hold, stop hold
   // ----------------------------------------------------------------
   always_comb begin
      // upper half of the index space clamps to the slowest row
      idx = rif.rate_index[IDX_MSB] ? 5'h1f : rif.rate_index[4:0];
      unique case (idx)
         5'h00: row = 32'h1407060b;
         5'h01: row = 32'h1607070c;
         5'h02: row = 32'h1808080d;
         5'h03: row = 32'h1a08090e;
         5'h04: row = 32'h1c090a0f;
         5'h05: row = 32'h1e090b10;
         5'h06: row = 32'h220a0d12;
         5'h07: row = 32'h280a1015;
         5'h08: row = 32'h1c070a0f;
         5'h09: row = 32'h20070c11;
         5'h0a: row = 32'h24090e13;
         5'h0b: row = 32'h28091015;
         5'h0c: row = 32'h2c0b1217;
         5'h0d: row = 32'h300b1419;
         5'h0e: row = 32'h380d181d;
         5'h0f: row = 32'h440d1e23;
         5'h10: row = 32'h30091219;
         5'h11: row = 32'h3809161d;
         5'h12: row = 32'h400d1a21;
         5'h13: row = 32'h480d1e25;
         5'h14: row = 32'h50112229;
         5'h15: row = 32'h5811262d;
         5'h16: row = 32'h68152e35;
         5'h17: row = 32'h80153a41;
         5'h18: row = 32'h50092629;
         5'h19: row = 32'h60092e31;
         5'h1a: row = 32'h70113639;
         5'h1b: row = 32'h80113e41;
         5'h1c: row = 32'h90194649;
         5'h1d: row = 32'ha0194e51;
         5'h1e: row = 32'hc0215e61;
         5'h1f: row = 32'hf0217679;
      endcase
      rif.scl_div = row[31:24];
      rif.sda_hold = row[23:16];
      rif.start_hold = row[15:8];
      rif.stop_hold = row[7:0];
   end
endmodule : rate_lookup

// ---- core/i2c_rate_ctrl.sv ----
`timescale 1ns/10ps
module i2c_rate_ctrl
   import rate_pkg::*;
(
   input wire logic core_clk, // 250 MHz bus clock
   input wire logic rst, // async, active high
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic scl_i, // clock line level
   output logic scl_o, // clock line drive value
   output logic scl_oe, // high while pulling clock low
   input wire logic sda_i, // data line level
   output logic sda_o, // data line drive value
   output logic sda_oe, // high while pulling data low
   input wire logic [7:0] rx_addr, // received address byte
   input wire logic rx_ten_bit, // byte is low part of a 10-bit address
   input wire logic rx_addr_valid, // one-cycle strobe with rx_addr
   output logic addr_match, // address matched own address
   output logic sda_update // pulse at each data change point
);
   import rate_pkg::*;

   rate_if rif ();
   rate_lookup u_lookup (.rif(rif));

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] scl_sync_q, sda_sync_q;
   logic scl_lvl_q, sda_lvl_q;
   logic scl_lvl_d, sda_lvl_d;

   always_comb begin
      // a level counts once the second and third stage agree
      scl_lvl_d = (scl_sync_q[1] == scl_sync_q[2]) ? scl_sync_q[2] : scl_lvl_q;
      sda_lvl_d = (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2] : sda_lvl_q;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         scl_sync_q <= 3'h7;
         sda_sync_q <= 3'h7;
         scl_lvl_q <= 1'b1;
         sda_lvl_q <= 1'b1;
      end else begin
         scl_sync_q <= {scl_sync_q[1:0], scl_i};
         sda_sync_q <= {sda_sync_q[1:0], sda_i};
         scl_lvl_q <= scl_lvl_d;
         sda_lvl_q <= sda_lvl_d;
      end
   end

   // ----------------------------------------------------------------
   // register bus slave
   // ----------------------------------------------------------------
   logic [7:0] own_slave_address_q, own_slave_address_d;
   logic [7:0] bit_rate_divider_q, bit_rate_divider_d;
   logic data_q, data_d;
   logic aw_full_q, aw_full_d, w_full_q, w_full_d;
   logic [7:0] waddr_q, waddr_d;
   logic [7:0] wbyte_q, wbyte_d;
   logic wen_q, wen_d;
   logic awready_q, awready_d, wready_q, wready_d;
   logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic do_wr, start_wr, stop_wr;
   logic busy;
   line_state_e st_q, st_d;
   logic match_q, match_d;

   always_comb begin
      own_slave_address_d = own_slave_address_q;
      bit_rate_divider_d = bit_rate_divider_q;
      data_d = data_q;
      aw_full_d = aw_full_q;
      w_full_d = w_full_q;
      waddr_d = waddr_q;
      wbyte_d = wbyte_q;
      wen_d = wen_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      start_wr = 1'b0;
      stop_wr = 1'b0;
      if (s_axi_awvalid && awready_q) begin
         aw_full_d = 1'b1;
         waddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
         w_full_d = 1'b1;
         wbyte_d = s_axi_wdata[7:0];
         wen_d = s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready)
         bvalid_d = 1'b0;
      do_wr = aw_full_q && w_full_q && !bvalid_q;
      if (do_wr) begin
         aw_full_d = 1'b0;
         w_full_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = AXI_OKAY;
         unique case (waddr_q)
            OWN_ADDR_OFS: if (wen_q) own_slave_address_d = wbyte_q;
            RATE_DIV_OFS: if (wen_q) bit_rate_divider_d = wbyte_q;
            CTRL_OFS: if (wen_q) begin
               start_wr = wbyte_q[CTL_START];
               stop_wr = wbyte_q[CTL_STOP];
               data_d = wbyte_q[CTL_DATA];
            end
            default: bresp_d = AXI_SLVERR;
         endcase
      end
      if (s_axi_rvalid && s_axi_rready)
         rvalid_d = 1'b0;
      if (s_axi_arvalid && arready_q) begin
         rvalid_d = 1'b1;
         rresp_d = AXI_OKAY;
         rdata_d = 32'h00000000;
         unique case (s_axi_araddr)
            OWN_ADDR_OFS: rdata_d[7:0] = own_slave_address_q;
            RATE_DIV_OFS: rdata_d[7:0] = bit_rate_divider_q;
            CTRL_OFS: begin
               rdata_d[STA_BUSY] = busy;
               rdata_d[STA_SCL] = scl_lvl_q;
               rdata_d[STA_SDA] = sda_lvl_q;
               rdata_d[STA_MATCH] = match_q;
            end
            default: rresp_d = AXI_SLVERR;
         endcase
      end
      awready_d = !aw_full_d;
      wready_d = !w_full_d;
      arready_d = !rvalid_d;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         own_slave_address_q <= OWN_ADDR_RST;
         bit_rate_divider_q <= RATE_DIV_RST;
         data_q <= 1'b1;
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         waddr_q <= 8'h00;
         wbyte_q <= 8'h00;
         wen_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= 2'h0;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rresp_q <= 2'h0;
         rdata_q <= 32'h00000000;
      end else begin
         own_slave_address_q <= own_slave_address_d;
         bit_rate_divider_q <= bit_rate_divider_d;
         data_q <= data_d;
         aw_full_q <= aw_full_d;
         w_full_q <= w_full_d;
         waddr_q <= waddr_d;
         wbyte_q <= wbyte_d;
         wen_q <= wen_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;

   // ----------------------------------------------------------------
   // address match
   // ----------------------------------------------------------------
   always_comb begin
      match_d = match_q;
      if (rx_addr_valid)
         match_d = rx_ten_bit ?
            (rx_addr[6:0] == own_slave_address_q[ADDR_MSB:ADDR_LSB]) :
            (rx_addr[7:1] == own_slave_address_q[ADDR_MSB:ADDR_LSB]);
   end

   // ----------------------------------------------------------------
   // line timing engine
   // ----------------------------------------------------------------
   // edges from a released clock pin to its filtered level
   localparam logic [CNT_W-1:0] SYNC_LAT = 10'h004;
   logic [1:0] sh_q, sh_d;
   logic [CNT_W-1:0] per_q, per_d, lo_q, lo_d, hi_q, hi_d;
   logic [CNT_W-1:0] sdah_q, sdah_d, sth_q, sth_d, sph_q, sph_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic start_pend_q, start_pend_d, stop_pend_q, stop_pend_d;
   logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d, upd_q, upd_d;

   assign rif.rate_index = bit_rate_divider_q[IDX_MSB:0];
   assign busy = (st_q != ST_IDLE);

   always_comb begin
      sh_d = sh_q;
      per_d = per_q;
      lo_d = lo_q;
      hi_d = hi_q;
      sdah_d = sdah_q;
      sth_d = sth_q;
      sph_d = sph_q;
      st_d = st_q;
      cnt_d = cnt_q + 10'h001;
      scl_oe_d = scl_oe_q;
      sda_oe_d = sda_oe_q;
      upd_d = 1'b0;
      // a request written in the cycle it completes is kept
      start_pend_d = start_pend_q;
      stop_pend_d = stop_pend_q;
      if (st_q == ST_IDLE) begin
         // settings only follow the registers between transfers
         unique case (bit_rate_divider_q[MUL_MSB:MUL_LSB])
            MUL_X2: sh_d = 2'd1;
            MUL_X4: sh_d = 2'd2;
            default: sh_d = 2'd0;
         endcase
         per_d = {2'b00, rif.scl_div} << sh_d;
         lo_d = per_d >> 1;
         hi_d = per_d - lo_d;
         sdah_d = {2'b00, rif.sda_hold} << sh_d;
         sth_d = {2'b00, rif.start_hold} << sh_d;
         sph_d = {2'b00, rif.stop_hold} << sh_d;
         cnt_d = '0;
         if (start_pend_q && scl_lvl_q && sda_lvl_q) begin
            sda_oe_d = 1'b1;
            st_d = ST_START;
         end
      end else if (st_q == ST_START) begin
         if (cnt_q == sth_q - 10'h001) begin
            scl_oe_d = 1'b1;
            start_pend_d = 1'b0;
            cnt_d = '0;
            st_d = ST_LOW;
         end
      end else if (st_q == ST_LOW) begin
         if (cnt_q == sdah_q - 10'h001) begin
            sda_oe_d = stop_pend_q | ~data_q;
            upd_d = 1'b1;
         end
         if (cnt_q == lo_q - 10'h001) begin
            scl_oe_d = 1'b0;
            cnt_d = '0;
            st_d = stop_pend_q ? ST_STOP : ST_HIGH;
         end
      end else if (st_q == ST_HIGH) begin
         // a slave holding the clock low stretches the high phase; the
         // filter delay itself still counts, so an unstretched period
         // stays exactly factor times divider
         if (!scl_lvl_q && (cnt_q >= SYNC_LAT))
            cnt_d = cnt_q;
         else if (cnt_q == hi_q - 10'h001) begin
            scl_oe_d = 1'b1;
            cnt_d = '0;
            st_d = ST_LOW;
         end
      end else begin
         if (cnt_q == sph_q - 10'h001) begin
            sda_oe_d = 1'b0;
            stop_pend_d = 1'b0;
            cnt_d = '0;
            st_d = ST_IDLE;
         end
      end
      if (start_wr)
         start_pend_d = 1'b1;
      if (stop_wr)
         stop_pend_d = 1'b1;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sh_q <= 2'd0;
         per_q <= '0;
         lo_q <= '0;
         hi_q <= '0;
         sdah_q <= '0;
         sth_q <= '0;
         sph_q <= '0;
         st_q <= ST_IDLE;
         cnt_q <= '0;
         start_pend_q <= 1'b0;
         stop_pend_q <= 1'b0;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         upd_q <= 1'b0;
         match_q <= 1'b0;
         scl_o <= 1'b0;
         sda_o <= 1'b0;
      end else begin
         sh_q <= sh_d;
         per_q <= per_d;
         lo_q <= lo_d;
         hi_q <= hi_d;
         sdah_q <= sdah_d;
         sth_q <= sth_d;
         sph_q <= sph_d;
         st_q <= st_d;
         cnt_q <= cnt_d;
         start_pend_q <= start_pend_d;
         stop_pend_q <= stop_pend_d;
         scl_oe_q <= scl_oe_d;
         sda_oe_q <= sda_oe_d;
         upd_q <= upd_d;
         match_q <= match_d;
         scl_o <= 1'b0;
         sda_o <= 1'b0;
      end
   end

   assign scl_oe = scl_oe_q;
   assign sda_oe = sda_oe_q;
   assign sda_update = upd_q;
   assign addr_match = match_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   property p_match7;
      rx_addr_valid && !rx_ten_bit && (rx_addr[7:1] == own_slave_address_q[7:1])
         |=> addr_match;
   endproperty
   a_match7: assert property (p_match7) else $error("7-bit match missed");
   property p_match10;
      rx_addr_valid && rx_ten_bit && (rx_addr[6:0] != own_slave_address_q[7:1])
         |=> !addr_match;
   endproperty
   a_match10: assert property (p_match10) else $error("10-bit false match");
   property p_mul;
      (st_q == ST_IDLE) |=>
         (sh_q == (($past(bit_rate_divider_q[7:6]) == 2'b10) ? 2'd2 :
                   ($past(bit_rate_divider_q[7:6]) == 2'b01) ? 2'd1 : 2'd0));
   endproperty
   a_mul: assert property (p_mul) else $error("multiplier decode wrong");
   property p_rsv;
      (st_q == ST_IDLE) && (bit_rate_divider_q[MUL_MSB:MUL_LSB] == 2'b11)
         |=> per_q == {2'b00, $past(rif.scl_div)};
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved factor not one");
   property p_freeze;
      (st_q != ST_IDLE) && $past(st_q != ST_IDLE) |-> $stable(per_q) && $stable(sph_q);
   endproperty
   a_freeze: assert property (p_freeze) else $error("settings moved mid transfer");
   property p_row0;
      (bit_rate_divider_q[5:0] == 6'h00) |-> (rif.scl_div == 8'h14) && (rif.stop_hold == 8'h0b);
   endproperty
   a_row0: assert property (p_row0) else $error("table row 00 wrong");
   property p_period;
      (st_q != ST_IDLE) |-> (per_q >= MIN_DIV) && (lo_q + hi_q == per_q);
   endproperty
   a_period: assert property (p_period) else $error("clock period wrong");
   sequence s_start_end;
      (st_q == ST_START) && (cnt_q == sth_q - 10'h001);
   endsequence
   property p_start;
      s_start_end |-> sda_oe_q && !scl_oe_q ##1 (st_q == ST_LOW) && scl_oe_q;
   endproperty
   a_start: assert property (p_start) else $error("start hold wrong");
   property p_hold;
      (st_q == ST_LOW) && (cnt_q != sdah_q) && !($past(st_q) == ST_HIGH) |=>
         $stable(sda_oe_q) || ($past(cnt_q) == sdah_q - 10'h001);
   endproperty
   a_hold: assert property (p_hold) else $error("data changed early");
   sequence s_stop_end;
      (st_q == ST_STOP) && (cnt_q == sph_q - 10'h001);
   endsequence
   property p_stop;
      s_stop_end |-> sda_oe_q && !scl_oe_q ##1 (st_q == ST_IDLE) && !sda_oe_q;
   endproperty
   a_stop: assert property (p_stop) else $error("stop hold wrong");
endmodule : i2c_rate_ctrl

// ---- testbench/bus_partner.sv ----
`timescale 1ns/10ps
module bus_partner (
   input wire logic core_clk, // bus clock
   input wire logic scl_oe, // controller pulls clock low
   input wire logic sda_oe, // controller pulls data low
   input wire logic [15:0] stretch, // cycles a slow slave holds clock low
   output logic scl, // resolved clock wire
   output logic sda // resolved data wire
);
   logic [15:0] hold_cnt = 16'h0000;
   // released wires float high through the pull-ups
   assign scl = ~(scl_oe | (hold_cnt != 16'h0000));
   assign sda = ~sda_oe;
   // reloaded while the controller pulls, so the hold starts with no gap
   always @(posedge core_clk) begin
      if (scl_oe === 1'b1) hold_cnt <= stretch;
      else if (hold_cnt != 16'h0000) hold_cnt <= hold_cnt - 16'h0001;
   end
endmodule : bus_partner

// ---- testbench/tb_i2c_bit_rate_and_slave_address.sv ----
`timescale 1ns/10ps
module tb_i2c_bit_rate_and_slave_address;
   import rate_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, rx_addr = 8'h00, own_m;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic rx_ten_bit = 0, rx_addr_valid = 0;
   logic awready, wready, bvalid, arready, rvalid, scl, sda;
   logic scl_o, scl_oe, sda_o, sda_oe, addr_match, sda_update;
   logic [1:0] bresp, rresp;
   logic [15:0] stretch = 16'h0000;
   int miscompares = 0, n_tests = 0, seed = 90942, div_m;
   int div_t[32] = '{20, 22, 24, 26, 28, 30, 34, 40, 28, 32, 36, 40, 44, 48,
      56, 68, 48, 56, 64, 72, 80, 88, 104, 128, 80, 96, 112, 128, 144, 160,
      192, 240};
   int sda_t[32] = '{7, 7, 8, 8, 9, 9, 10, 10, 7, 7, 9, 9, 11, 11, 13, 13, 9,
      9, 13, 13, 17, 17, 21, 21, 9, 9, 17, 17, 25, 25, 33, 33};
   int sta_t[32] = '{6, 7, 8, 9, 10, 11, 13, 16, 10, 12, 14, 16, 18, 20, 24,
      30, 18, 22, 26, 30, 34, 38, 46, 58, 38, 46, 54, 62, 70, 78, 94, 118};
   int sto_t[32] = '{11, 12, 13, 14, 15, 16, 18, 21, 15, 17, 19, 21, 23, 25,
      29, 35, 25, 29, 33, 37, 41, 45, 53, 65, 41, 49, 57, 65, 73, 81, 97, 121};
   always #2 core_clk = ~core_clk;
   i2c_rate_ctrl dut (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .scl_i(scl),
      .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .rx_addr(rx_addr), .rx_ten_bit(rx_ten_bit),
      .rx_addr_valid(rx_addr_valid), .addr_match(addr_match),
      .sda_update(sda_update));
   bus_partner far_end (.core_clk(core_clk), .scl_oe(scl_oe),
      .sda_oe(sda_oe), .stretch(stretch), .scl(scl), .sda(sda));
   // ----------------------------------------------------------------
   // checking and bus tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("comparisons=%0d mismatches=%0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic hang;
      miscompares++;
      tally_and_finish();
   endtask : hang
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      int n;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge core_clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      r = bresp;
      bready <= 1'b0;
      if (n == 100) hang();
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      int n;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge core_clk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (n == 100) hang();
   endtask : axi_rd
   // edges until the chosen line condition is seen; sel 3 is the stop hold
   task automatic wait_for(input int sel, input logic lvl, output int n);
      logic s;
      for (n = 1; n < 5000; n++) begin
         @(posedge core_clk);
         s = sel == 0 ? scl_oe : sel == 1 ? sda_oe :
             sel == 2 ? sda_update : (!scl_oe && sda_oe);
         if (s === lvl) return;
      end
      hang();
   endtask : wait_for
   task automatic run_rate(input logic [1:0] mc, input int idx, input int st);
      int m, t, n1, n2, n3, n4;
      logic [31:0] d;
      logic [1:0] r;
      m = mc == MUL_X2 ? 2 : mc == MUL_X4 ? 4 : 1;
      t = idx > 31 ? 31 : idx;
      div_m = mc * 64 + idx;
      stretch <= 16'(st);
      axi_wr(RATE_DIV_OFS, 32'(div_m), r);
      axi_rd(RATE_DIV_OFS, d, r);
      chk(d, 32'(div_m));
      axi_wr(CTRL_OFS, 32'h5, r);
      wait_for(1, 1'b1, n1);
      wait_for(0, 1'b1, n1);
      chk(n1, m * sta_t[t]);
      wait_for(2, 1'b1, n2);
      chk(n2, m * sda_t[t]);
      chk({scl_o, sda_o, sda_oe}, 3'b000);
      wait_for(0, 1'b0, n3);
      chk(n2 + n3, m * div_t[t] / 2);
      wait_for(0, 1'b1, n4);
      if (st == 0) chk(n2 + n3 + n4, m * div_t[t]);
      else chk(n2 + n3 + n4 >= m * div_t[t] + st, 1);
      stretch <= 16'h0000;
      axi_wr(CTRL_OFS, 32'h6, r);
      wait_for(3, 1'b1, n1);
      wait_for(1, 1'b0, n1);
      chk(n1, m * sto_t[t]);
   endtask : run_rate
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [7:0] a;
      int i;
      own_m = OWN_ADDR_RST;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      axi_rd(OWN_ADDR_OFS, d, r);
      chk(d, 32'(own_m));
      axi_rd(RATE_DIV_OFS, d, r);
      chk(d, 32'(RATE_DIV_RST));
      axi_rd(8'h0c, d, r);
      chk(d, 32'h0);
      chk(r, AXI_SLVERR);
      axi_wr(8'h0c, 32'h5a, r);
      chk(r, AXI_SLVERR);
      d = $random(seed);
      axi_wr(OWN_ADDR_OFS, d, r);
      chk(r, AXI_OKAY);
      own_m = d[7:0];
      axi_rd(OWN_ADDR_OFS, d, r);
      chk(d, 32'(own_m));
      // masked low lane: answered, but the register keeps its value
      wstrb <= 4'h0;
      axi_wr(OWN_ADDR_OFS, ~d, r);
      wstrb <= 4'hf;
      chk(r, AXI_OKAY);
      axi_rd(OWN_ADDR_OFS, d, r);
      chk(d, 32'(own_m));
      for (i = 0; i < 8; i++) begin
         a = 8'($random(seed));
         @(posedge core_clk);
         rx_ten_bit <= i[0];
         rx_addr <= i < 4 ? a : i[0] ? {a[7], own_m[7:1]} : {own_m[7:1], a[0]};
         rx_addr_valid <= 1'b1;
         @(posedge core_clk);
         rx_addr_valid <= 1'b0;
         @(posedge core_clk);
         chk(addr_match, i[0] ? rx_addr[6:0] == own_m[7:1] :
             rx_addr[7:1] == own_m[7:1]);
      end
      // idle, both lines high, last strobe matched
      axi_rd(CTRL_OFS, d, r);
      chk(d, 32'((1 << STA_MATCH) | (1 << STA_SDA) | (1 << STA_SCL)));
      run_rate(MUL_X1, 0, 0);
      run_rate(MUL_X2, 7, 0);
      run_rate(MUL_X4, 31, 0);
      run_rate(2'b11, 11, 0);
      run_rate(MUL_X1, 37, 0);
      run_rate(MUL_X1, 0, 9);
      tally_and_finish();
   end
endmodule : tb_i2c_bit_rate_and_slave_address
